// ==== src/bmc_mode_ctrl.sv ====
// beacon mode controller: modes, self-test, indicator and buzzer, tx gating
// assumes a seconds tick pin and self-test check inputs held stable
`timescale 1ns/100ps
`default_nettype none
`include "bmc_regs.svh"
module bmc_mode_ctrl #(
    parameter int CNT_W = 16,
    parameter int MS_CYCLES = `BMC_MS_CYCLES
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // front switch, remote panel and crash sensor
    input wire logic SW_ARM_IN,
    input wire logic SW_ON_IN,
    input wire logic REMOTE_RESET_TEST_IN,
    input wire logic REMOTE_ACTIVATE_IN,
    input wire logic CRASH_SENSOR_IN,
    // timebase
    input wire logic SEC_TICK_IN,
    // self-test checks
    input wire logic BATT_LOW_IN,
    input wire logic TX_POWER_LOW_IN,
    input wire logic SYNTH_UNLOCK_IN,
    input wire logic ID_PROGRAMMED_IN,
    // mode and outputs
    output logic [2:0] MODE_OUT,
    output logic HOMING_TX_EN_OUT,
    output logic BURST_TX_EN_OUT,
    output logic INDICATOR_OUT,
    output logic BUZZER_OUT,
    output logic REMOTE_INDICATOR_OUT,
    output logic REMOTE_SOUNDER_OUT,
    output logic REMOTE_PANEL_PWR_OUT,
    output logic TEST_LINK_EN_OUT,
    output logic SELFTEST_FAIL_OUT,
    output logic [2:0] FAIL_CODE_OUT,
    // counters for test equipment
    output logic [CNT_W-1:0] SELFTEST_COUNT_OUT,
    output logic [CNT_W-1:0] BURST_COUNT_OUT
);
    function automatic logic [15:0] ms_flash(input logic [15:0] ms);
        ms_flash = ms;
    endfunction

    logic [6:0] pin_s;
    logic sw_arm, sw_on, rem_rst, rem_on, crash, tick_lvl;
    logic tick_d_ff;
    bmc_sync #(.WIDTH(7)) u_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in({SEC_TICK_IN, CRASH_SENSOR_IN, REMOTE_ACTIVATE_IN, REMOTE_RESET_TEST_IN,
               SW_ON_IN, SW_ARM_IN, 1'b0}),
        .q_out(pin_s)
    );
    assign sw_arm = pin_s[1] & ~pin_s[2];
    assign sw_on = pin_s[2];
    assign rem_rst = pin_s[3];
    assign rem_on = pin_s[4];
    assign crash = pin_s[5];
    assign tick_lvl = pin_s[6];

    bmc_pkg::bmc_switch_t sw_pos, sw_prev_ff;
    assign sw_pos = sw_on ? bmc_pkg::BMC_SW_ON : (sw_arm ? bmc_pkg::BMC_SW_ARM : bmc_pkg::BMC_SW_OFF);

    wire sec = tick_lvl & ~tick_d_ff;
    wire rem_rst_rise;
    logic rem_rst_d_ff;
    assign rem_rst_rise = rem_rst & ~rem_rst_d_ff;

    bmc_pkg::bmc_mode_t mode_ff, nxt_mode;
    logic st_to_on_ff, nxt_st_to_on;
    logic [2:0] st_sec_ff;
    logic [16:0] on_sec_ff;
    logic [5:0] burst_sec_ff;
    logic fail_ff;
    logic [2:0] code_ff;

    // failure classification
    wire [2:0] fail_code = BATT_LOW_IN ? `BMC_CODE_LOW_BATT :
                           TX_POWER_LOW_IN ? `BMC_CODE_LOW_POWER :
                           SYNTH_UNLOCK_IN ? `BMC_CODE_SYNTH_LOCK :
                           !ID_PROGRAMMED_IN ? `BMC_CODE_NO_ID : 3'h0;

    wire st_done = (mode_ff == bmc_pkg::BMC_SELFTEST) && sec &&
                   (st_sec_ff == 3'(`BMC_SELFTEST_MAX_S - 1));
    wire enter_st = ((sw_prev_ff == bmc_pkg::BMC_SW_OFF) && (sw_pos == bmc_pkg::BMC_SW_ARM)) ||
                    (sw_arm && rem_rst_rise && mode_ff != bmc_pkg::BMC_SELFTEST);
    wire want_on = (sw_pos == bmc_pkg::BMC_SW_ON && sw_prev_ff != bmc_pkg::BMC_SW_ON) ||
                   (sw_arm && (rem_on || crash) && mode_ff == bmc_pkg::BMC_ARMED);

    always_comb begin
        nxt_mode = mode_ff;
        nxt_st_to_on = st_to_on_ff;
        case (mode_ff)
            bmc_pkg::BMC_OFF: begin
                if (enter_st) begin
                    nxt_mode = bmc_pkg::BMC_SELFTEST;
                    nxt_st_to_on = 1'b0;
                end else if (want_on) begin
                    nxt_mode = bmc_pkg::BMC_SELFTEST;
                    nxt_st_to_on = 1'b1;
                end
            end
            bmc_pkg::BMC_SELFTEST: begin
                // switch moved to on mid-test: go on after the
                if (sw_pos == bmc_pkg::BMC_SW_ON) begin
                    nxt_st_to_on = 1'b1;
                end
                // activation while armed is kept, not lost
                if (sw_arm && (rem_on || crash)) begin
                    nxt_st_to_on = 1'b1;
                end
                if (st_done) begin
                    nxt_mode = st_to_on_ff ? bmc_pkg::BMC_ON : bmc_pkg::BMC_ARMED;
                end
            end
            bmc_pkg::BMC_ARMED: begin
                if (want_on) begin
                    nxt_mode = bmc_pkg::BMC_SELFTEST;
                    nxt_st_to_on = 1'b1;
                end else if (enter_st) begin
                    nxt_mode = bmc_pkg::BMC_SELFTEST;
                    nxt_st_to_on = 1'b0;
                end
            end
            bmc_pkg::BMC_ON: begin
                if (sw_arm && rem_rst_rise) begin
                    nxt_mode = bmc_pkg::BMC_ARMED;
                end
            end
            default: nxt_mode = bmc_pkg::BMC_OFF;
        endcase
        if (sw_pos == bmc_pkg::BMC_SW_OFF) begin
            nxt_mode = bmc_pkg::BMC_OFF;
        end
    end

    // millisecond pattern timer, resets on mode change
    logic [24:0] cyc_ff;
    logic [15:0] ms_ff;
    wire ms_tick = (cyc_ff == 25'(MS_CYCLES - 1));
    // wrap on a whole pattern period so flash and beep stay even
    wire ms_wrap = (ms_ff == 16'hea5f);
    wire mode_chg = (nxt_mode != mode_ff);

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mode_ff <= bmc_pkg::BMC_OFF;
            st_to_on_ff <= 1'b0;
            sw_prev_ff <= bmc_pkg::BMC_SW_OFF;
            tick_d_ff <= 1'b0;
            rem_rst_d_ff <= 1'b0;
            cyc_ff <= '0;
            ms_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
            st_to_on_ff <= nxt_st_to_on;
            sw_prev_ff <= sw_pos;
            tick_d_ff <= tick_lvl;
            rem_rst_d_ff <= rem_rst;
            cyc_ff <= (mode_chg || ms_tick) ? 25'h0 : cyc_ff + 25'h1;
            ms_ff <= mode_chg ? 16'h0 : (ms_tick ? (ms_wrap ? 16'h0 : ms_ff + 16'h1) : ms_ff);
        end
    end

    // self-test and on-mode second counters
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            st_sec_ff <= '0;
            on_sec_ff <= '0;
            burst_sec_ff <= '0;
            fail_ff <= 1'b0;
            code_ff <= '0;
        end else begin
            if (mode_chg) begin
                st_sec_ff <= '0;
                on_sec_ff <= '0;
                burst_sec_ff <= '0;
            end else if (sec) begin
                st_sec_ff <= st_sec_ff + 3'h1;
                if (on_sec_ff != 17'(`BMC_BURST_STOP_S)) begin
                    on_sec_ff <= on_sec_ff + 17'h1;
                end
                burst_sec_ff <= (burst_sec_ff == 6'(`BMC_BURST_PERIOD_S - 1)) ? 6'h0 : burst_sec_ff + 6'h1;
            end
            if (mode_ff == bmc_pkg::BMC_SELFTEST && st_sec_ff == 3'h0) begin
                fail_ff <= (fail_code != 3'h0);
                code_ff <= fail_code;
            end
        end
    end

    // burst trigger every fifty seconds within the first day
    wire burst_start = (mode_ff == bmc_pkg::BMC_ON) && sec && !mode_chg &&
                       (burst_sec_ff == 6'(`BMC_BURST_PERIOD_S - 1)) &&
                       (on_sec_ff < 17'(`BMC_BURST_STOP_S));
    logic [15:0] burst_ms_ff;
    logic burst_ff;
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            burst_ff <= 1'b0;
            burst_ms_ff <= '0;
        end else if (mode_ff != bmc_pkg::BMC_ON || mode_chg) begin
            burst_ff <= 1'b0;
            burst_ms_ff <= '0;
        end else if (burst_start) begin
            burst_ff <= 1'b1;
            burst_ms_ff <= '0;
        end else if (burst_ff && ms_tick) begin
            burst_ms_ff <= burst_ms_ff + 16'h1;
            if (burst_ms_ff == ms_flash(16'(`BMC_BURST_MS - 1))) begin
                burst_ff <= 1'b0;
            end
        end
    end

    // counters survive reset: no reset branch
    logic [CNT_W-1:0] st_cnt_ff = '0;
    logic [CNT_W-1:0] burst_cnt_ff = '0;
    always_ff @(posedge CLK_IN) begin
        if (st_done) begin
            st_cnt_ff <= st_cnt_ff + 1'b1;
        end
        if (burst_start) begin
            burst_cnt_ff <= burst_cnt_ff + 1'b1;
        end
    end

    // self-test result flash pattern, starting at three seconds
    localparam int RES_MS = `BMC_RESULT_AT_S * 1000;
    localparam int SF = `BMC_SHORT_FLASH_MS;
    wire [15:0] rel_ms = ms_ff - 16'(RES_MS);
    wire in_res = (ms_ff >= 16'(RES_MS));
    wire [4:0] slot = 5'(rel_ms / 16'(2 * SF));
    wire slot_on = ((rel_ms % 16'(2 * SF)) < 16'(SF));
    wire [4:0] n_fl = 5'(`BMC_FAIL_PREFIX) + {2'b00, code_ff};
    wire res_ind = in_res && (fail_ff ? (slot_on && slot < n_fl)
                                      : (rel_ms < ms_flash(16'(`BMC_LONG_FLASH_MS))));
    // transmit-mode patterns
    wire [15:0] ph = ms_ff % 16'(`BMC_BEEP_PERIOD_MS);
    wire homing_flash = (ms_ff % 16'h03e8) < 16'h0064;
    wire homing_beep = ph < 16'h0064;

    wire is_on = (mode_ff == bmc_pkg::BMC_ON);
    wire is_st = (mode_ff == bmc_pkg::BMC_SELFTEST);
    wire nxt_ind = is_st ? res_ind : (is_on ? (burst_ff ? 1'b1 : homing_flash) : 1'b0);
    wire nxt_buz = is_st ? 1'b1 : (is_on ? (!burst_ff && homing_beep) : 1'b0);

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            MODE_OUT <= 3'h0;
            HOMING_TX_EN_OUT <= 1'b0;
            BURST_TX_EN_OUT <= 1'b0;
            INDICATOR_OUT <= 1'b0;
            BUZZER_OUT <= 1'b0;
            REMOTE_INDICATOR_OUT <= 1'b0;
            REMOTE_SOUNDER_OUT <= 1'b0;
            REMOTE_PANEL_PWR_OUT <= 1'b0;
            TEST_LINK_EN_OUT <= 1'b0;
            SELFTEST_FAIL_OUT <= 1'b0;
            FAIL_CODE_OUT <= 3'h0;
            SELFTEST_COUNT_OUT <= '0;
            BURST_COUNT_OUT <= '0;
        end else begin
            MODE_OUT <= mode_ff;
            HOMING_TX_EN_OUT <= is_on;
            BURST_TX_EN_OUT <= is_on && burst_ff;
            INDICATOR_OUT <= nxt_ind;
            BUZZER_OUT <= nxt_buz;
            REMOTE_INDICATOR_OUT <= nxt_ind;
            REMOTE_SOUNDER_OUT <= nxt_buz;
            REMOTE_PANEL_PWR_OUT <= sw_arm;
            TEST_LINK_EN_OUT <= is_st;
            SELFTEST_FAIL_OUT <= fail_ff;
            FAIL_CODE_OUT <= code_ff;
            SELFTEST_COUNT_OUT <= st_cnt_ff;
            BURST_COUNT_OUT <= burst_cnt_ff;
        end
    end
endmodule // bmc_mode_ctrl
`default_nettype wire

// ==== src/bmc_regs.svh ====
// constants for the beacon mode controller: timing counts, flash codes
// assumes a one-pulse-per-second tick and a 25 MHz system clock
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH
`define BMC_CLK_HZ 25000000
`define BMC_SELFTEST_MAX_S 5
`define BMC_RESULT_AT_S 3
`define BMC_BURST_PERIOD_S 50
`define BMC_BURST_HOURS 24
`define BMC_BURST_STOP_S (`BMC_BURST_HOURS * 3600)
`define BMC_LONG_FLASH_MS 1000
`define BMC_SHORT_FLASH_MS 60
`define BMC_BEEP_PERIOD_MS 500
`define BMC_BURST_MS 440
`define BMC_MS_CYCLES (`BMC_CLK_HZ / 1000)
`define BMC_FAIL_PREFIX 3
`define BMC_CODE_LOW_BATT 3'h1
`define BMC_CODE_LOW_POWER 3'h2
`define BMC_CODE_SYNTH_LOCK 3'h3
`define BMC_CODE_NO_ID 3'h4
`endif

// ==== src/bmc_pkg.sv ====
// types for the beacon mode controller
// assumes nothing of its surroundings
package bmc_pkg;
    typedef enum logic [2:0] {
        BMC_OFF = 3'b000,
        BMC_SELFTEST = 3'b001,
        BMC_ARMED = 3'b010,
        BMC_ON = 3'b011
    } bmc_mode_t;
    typedef enum logic [1:0] {
        BMC_SW_OFF = 2'b00,
        BMC_SW_ARM = 2'b01,
        BMC_SW_ON = 2'b10
    } bmc_switch_t;
endpackage

// ==== src/bmc_sync.sv ====
// three-stage synchroniser for asynchronous pins
// assumes one clock; output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module bmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] nxt_q;
    integer i;
    always_comb begin
        nxt_q = q_out;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_q[i] = s3_ff[i];
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_out <= '0;
        end else begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_out <= nxt_q;
        end
    end
endmodule // bmc_sync
`default_nettype wire

// ==== testbench/bmc_mode_ctrl_assertions.sv ====
// checker for the beacon mode controller, ports only
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module bmc_chk #(
    parameter int CNT_W = 16,
    parameter int MS_CYCLES = 25000
) (
    // clock, reset, switch
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic SW_ARM_IN,
    // design outputs
    input wire logic [2:0] MODE_OUT,
    input wire logic HOMING_TX_EN_OUT,
    input wire logic BURST_TX_EN_OUT,
    input wire logic INDICATOR_OUT,
    input wire logic BUZZER_OUT,
    input wire logic REMOTE_INDICATOR_OUT,
    input wire logic REMOTE_SOUNDER_OUT,
    input wire logic REMOTE_PANEL_PWR_OUT,
    input wire logic [CNT_W-1:0] BURST_COUNT_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    localparam int BURST_CYC = 440 * MS_CYCLES;
    logic [31:0] burst_len_ff;
    logic [31:0] nxt_burst_len;
    // length of the burst in progress
    assign nxt_burst_len = BURST_TX_EN_OUT ? burst_len_ff + 32'h1 : 32'h0;
    always_ff @(posedge CLK_IN) begin
        burst_len_ff <= nxt_burst_len;
    end
    sequence s_burst_held;
        BURST_TX_EN_OUT ##1 BURST_TX_EN_OUT;
    endsequence
    property p_mode_legal;
        MODE_OUT <= 3'h3;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");
    property p_st_buzz;
        (MODE_OUT == 3'h1) [*2] |-> BUZZER_OUT || $past(BUZZER_OUT);
    endproperty
    a_st_buzz: assert property (p_st_buzz) else $error("buzzer off in self-test");
    property p_panel_pwr;
        (!SW_ARM_IN) [*8] |-> !REMOTE_PANEL_PWR_OUT;
    endproperty
    a_panel_pwr: assert property (p_panel_pwr) else $error("panel powered off arm");
    property p_homing;
        HOMING_TX_EN_OUT |-> MODE_OUT == 3'h3;
    endproperty
    a_homing: assert property (p_homing) else $error("homing outside on mode");
    property p_burst_len;
        $fell(BURST_TX_EN_OUT) && HOMING_TX_EN_OUT |-> burst_len_ff == BURST_CYC;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
    property p_burst_quiet;
        s_burst_held |-> !BUZZER_OUT && INDICATOR_OUT;
    endproperty
    a_burst_quiet: assert property (p_burst_quiet) else $error("burst cues wrong");
    property p_mirror;
        REMOTE_INDICATOR_OUT == INDICATOR_OUT && REMOTE_SOUNDER_OUT == BUZZER_OUT;
    endproperty
    a_mirror: assert property (p_mirror) else $error("remote cues differ");
    property p_burst_cnt;
        $rose(BURST_TX_EN_OUT) |-> ##[0:2] $changed(BURST_COUNT_OUT);
    endproperty
    a_burst_cnt: assert property (p_burst_cnt) else $error("burst not counted");
endmodule // bmc_chk
bind bmc_mode_ctrl bmc_chk #(.CNT_W(CNT_W), .MS_CYCLES(MS_CYCLES)) u_bmc_chk (
    .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .SW_ARM_IN(SW_ARM_IN),
    .MODE_OUT(MODE_OUT), .HOMING_TX_EN_OUT(HOMING_TX_EN_OUT),
    .BURST_TX_EN_OUT(BURST_TX_EN_OUT), .INDICATOR_OUT(INDICATOR_OUT),
    .BUZZER_OUT(BUZZER_OUT), .REMOTE_INDICATOR_OUT(REMOTE_INDICATOR_OUT),
    .REMOTE_SOUNDER_OUT(REMOTE_SOUNDER_OUT), .REMOTE_PANEL_PWR_OUT(REMOTE_PANEL_PWR_OUT),
    .BURST_COUNT_OUT(BURST_COUNT_OUT));
`default_nettype wire

// ==== testbench/bmc_panel_model.sv ====
// remote panel model: switch lines into the beacon
// assumes the bench sets the wanted switch positions
`timescale 1ns/100ps
`default_nettype none
module bmc_panel_model (
    // power from the beacon
    input wire logic pwr_in,
    // wanted switch positions
    input wire logic want_on_in,
    input wire logic want_reset_in,
    // lines into the beacon
    output logic on_out,
    output logic reset_out
);
    // unpowered panel leaves its lines at the pull-down
    assign on_out = pwr_in & want_on_in;
    assign reset_out = pwr_in & want_reset_in;
endmodule // bmc_panel_model
`default_nettype wire

// ==== testbench/bmc_mode_ctrl_tb.sv ====
// self-checking bench for the beacon mode controller
// assumes the panel model and checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module bmc_mode_ctrl_tb;
    typedef struct packed {logic [3:0] chk; logic [2:0] code; logic [3:0] fl;} bmc_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sw_arm = 1'b0;
    logic sw_on = 1'b0;
    logic crash = 1'b0;
    logic tick = 1'b0;
    logic want_on = 1'b0;
    logic want_rst = 1'b0;
    logic [3:0] chk_in = 4'h1;
    wire logic rem_on, rem_rst, homing, burst, ind, buz, ppwr, link, fail;
    wire logic [2:0] mode, code;
    wire logic [15:0] st_cnt, b_cnt;
    int fail_count = 0;
    int check_count = 0;
    int tick_per = 1000;
    int n = 0;
    int flashes = 0;
    int beeps = 0;
    int st_exp = 0;
    // check inputs {batt, power, synth, id}, code, indicator flashes
    bmc_row_t rows [5] = '{'{4'h1, 3'h0, 4'h1}, '{4'h9, 3'h1, 4'h4}, '{4'h5, 3'h2, 4'h5},
        '{4'h3, 3'h3, 4'h6}, '{4'h0, 3'h4, 4'h7}};
    bmc_mode_ctrl #(.CNT_W(16), .MS_CYCLES(1)) u_bmc_mode_ctrl (
        .CLK_IN(clk), .SYS_RST_IN(rst), .SW_ARM_IN(sw_arm), .SW_ON_IN(sw_on),
        .REMOTE_RESET_TEST_IN(rem_rst), .REMOTE_ACTIVATE_IN(rem_on), .CRASH_SENSOR_IN(crash),
        .SEC_TICK_IN(tick), .BATT_LOW_IN(chk_in[3]), .TX_POWER_LOW_IN(chk_in[2]),
        .SYNTH_UNLOCK_IN(chk_in[1]), .ID_PROGRAMMED_IN(chk_in[0]), .MODE_OUT(mode),
        .HOMING_TX_EN_OUT(homing), .BURST_TX_EN_OUT(burst), .INDICATOR_OUT(ind),
        .BUZZER_OUT(buz), .REMOTE_INDICATOR_OUT(), .REMOTE_SOUNDER_OUT(),
        .REMOTE_PANEL_PWR_OUT(ppwr), .TEST_LINK_EN_OUT(link), .SELFTEST_FAIL_OUT(fail),
        .FAIL_CODE_OUT(code), .SELFTEST_COUNT_OUT(st_cnt), .BURST_COUNT_OUT(b_cnt));
    bmc_panel_model u_bmc_panel_model (.pwr_in(ppwr), .want_on_in(want_on),
        .want_reset_in(want_rst), .on_out(rem_on), .reset_out(rem_rst));
    initial begin
        forever #20 clk = ~clk;
    end
    // seconds timebase, high for three clocks
    initial begin
        forever begin
            repeat (tick_per - 3) @(posedge clk);
            #1 tick = 1'b1;
            repeat (3) @(posedge clk);
            #1 tick = 1'b0;
        end
    end
    always @(posedge tick) n++;
    always @(posedge ind) flashes++;
    always @(posedge buz) beeps++;
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wait_until(input logic [2:0] m, input logic b);
        int t;
        t = 0;
        while ((mode !== m || burst !== b) && t < 8000) begin
            step(1);
            t++;
        end
        if (t >= 8000) begin
            fail_count++;
            $display("wrong value at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask
    initial begin
        step(11);
        `CHK(mode, 3'h0)
        step(1);
        rst = 1'b0;
        // one self-test per row from off to arm
        for (int i = 0; i < 5; i++) begin
            chk_in = rows[i].chk;
            sw_arm = 1'b0;
            step(20);
            sw_arm = 1'b1;
            flashes = 0;
            step(2000);
            `CHK(link, 1'b1)
            `CHK(buz, 1'b1)
            step(4000);
            st_exp++;
            `CHK(flashes, int'(rows[i].fl))
            `CHK(fail, rows[i].code != 3'h0)
            `CHK(code, rows[i].code)
            `CHK(mode, 3'h2)
            `CHK(st_cnt, 16'(st_exp))
            `CHK(ppwr, 1'b1)
        end
        // remote test, then remote on, then remote reset
        chk_in = 4'h1;
        want_rst = 1'b1;
        step(10);
        want_rst = 1'b0;
        wait_until(3'h1, 1'b0);
        `CHK(mode, 3'h1)
        wait_until(3'h2, 1'b0);
        want_on = 1'b1;
        wait_until(3'h1, 1'b0);
        wait_until(3'h3, 1'b0);
        want_on = 1'b0;
        `CHK(homing, 1'b1)
        flashes = 0;
        beeps = 0;
        step(1000);
        `CHK(beeps, 2)
        `CHK(flashes, 1)
        want_rst = 1'b1;
        wait_until(3'h2, 1'b0);
        want_rst = 1'b0;
        `CHK(homing, 1'b0)
        // crash refused with the switch off
        sw_arm = 1'b0;
        crash = 1'b1;
        step(50);
        `CHK(mode, 3'h0)
        `CHK(ppwr, 1'b0)
        crash = 1'b0;
        // switch on with fast seconds, run to the first burst
        tick_per = 100;
        sw_on = 1'b1;
        wait_until(3'h3, 1'b0);
        n = 0;
        wait_until(3'h3, 1'b1);
        `CHK(n, 50)
        step(5);
        `CHK(buz, 1'b0)
        `CHK(ind, 1'b1)
        `CHK(b_cnt, 16'h1)
        sw_on = 1'b0;
        wait_until(3'h0, 1'b0);
        `CHK(homing, 1'b0)
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(3);
        `CHK(st_cnt, 16'(st_exp + 3))
        `CHK(b_cnt, 16'h1)
        give_verdict();
    end
endmodule // bmc_mode_ctrl_tb
`default_nettype wire
